//--- logic/bfs_pkg.sv
package bfs_pkg;
   localparam logic [5:0] SR1_ADDR = 6'h05;
   localparam logic [5:0] SR2_ADDR = 6'h06;
   localparam int SR_W = 24;
   localparam logic [23:0] SR_RESET = 24'h00_0000;
   localparam int PAR_BIT = 0;
   // First status register fields.
   localparam int SR1_VLED1_HI = 23;
   localparam int SR1_VLED1_LO = 16;
   localparam int SR1_VLED2_HI = 15;
   localparam int SR1_VLED2_LO = 8;
   localparam int SR1_CH1_SHORT_CIRCUIT = 7;
   localparam int SR1_SHT2 = 6;
   localparam int SR1_CH1_OVERTEMP_LATCH = 5;
   localparam int SR1_TWH1 = 4;
   localparam int SR1_TWL1 = 3;
   localparam int SR1_MIN1 = 2;
   localparam int SR1_MIN2 = 1;
   // Second status register fields.
   localparam int SR2_CH2_OVERTEMP_LATCH = 23;
   localparam int SR2_TWH2 = 22;
   localparam int SR2_TWL2 = 21;
   localparam int SR2_MAX1 = 20;
   localparam int SR2_MAX2 = 19;
   localparam int SR2_DCLK = 18;
   localparam int SR2_HSUP = 17;
   localparam int SR2_WDST_HI = 16;
   localparam int SR2_WDST_LO = 15;
   localparam int SR2_WDF = 14;
   localparam int SR2_UV = 13;
   localparam int SR2_TOFMIN1 = 12;
   localparam int SR2_TOFMIN2 = 11;
   localparam int SR2_TOFMAX1 = 10;
   localparam int SR2_TOFMAX2 = 9;
   localparam int SR2_NPG = 8;
   localparam int SR2_BSTFB = 6;
   localparam int SR2_DIN = 5;
   // Timing.
   localparam int CLK_MHZ = 40;
   localparam int OVT_FILT_US = 20;
   localparam int OVT_FILT_CYC = OVT_FILT_US * CLK_MHZ;
   localparam int OVT_CNT_W = 10;
   localparam int AUTORESTART_MS = 10;
   localparam int AUTORESTART_CYC = AUTORESTART_MS * 1000 * CLK_MHZ;
   localparam int AR_CNT_W = 19;
   localparam int SHORT_ON_LIMIT = 32;
   localparam int SHORT_CNT_W = 6;
endpackage

//--- logic/bfs_therm_if.sv
`timescale 1ns/10ps
`default_nettype none
interface bfs_therm_if;
   logic ge_shutdown;
   logic below_shutdown_hys;
   logic ge_warn_high;
   logic below_warn_high_hys;
   logic ge_warn_low;
   logic below_warn_low_hys;
   logic hot;
   logic cool;
   logic warn_high;
   logic warn_low;
   modport chan (input ge_shutdown, below_shutdown_hys, ge_warn_high,
      below_warn_high_hys, ge_warn_low, below_warn_low_hys,
      output hot, cool, warn_high, warn_low);
   modport core (output ge_shutdown, below_shutdown_hys, ge_warn_high,
      below_warn_high_hys, ge_warn_low, below_warn_low_hys,
      input hot, cool, warn_high, warn_low);
endinterface
`default_nettype wire

//--- logic/bfs_therm_chan.sv
`timescale 1ns/10ps
`default_nettype none
module bfs_therm_chan
(
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   bfs_therm_if.chan th
);
   logic [5:0] sync1_reg;
   logic [5:0] sync2_reg;
   logic [bfs_pkg::OVT_CNT_W-1:0] filt_reg;
   logic [bfs_pkg::OVT_CNT_W-1:0] filt_next;
   logic warn_high_reg;
   logic warn_high_next;
   logic warn_low_reg;
   logic warn_low_next;
   localparam logic [bfs_pkg::OVT_CNT_W-1:0] FILT_MAX =
      bfs_pkg::OVT_CNT_W'(bfs_pkg::OVT_FILT_CYC);

   always_comb
   begin
      filt_next = '0;
      if (sync2_reg[0])
      begin
         filt_next = (filt_reg == FILT_MAX) ? filt_reg : filt_reg + 1'b1;
      end
      warn_high_next = warn_high_reg;
      if (sync2_reg[2])
      begin
         warn_high_next = 1'b1;
      end
      else if (sync2_reg[3])
      begin
         warn_high_next = 1'b0;
      end
      warn_low_next = warn_low_reg;
      if (sync2_reg[4])
      begin
         warn_low_next = 1'b1;
      end
      else if (sync2_reg[5])
      begin
         warn_low_next = 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         filt_reg <= '0;
         warn_high_reg <= 1'b0;
         warn_low_reg <= 1'b0;
      end
      else
      begin
         sync1_reg <= {th.below_warn_low_hys, th.ge_warn_low,
            th.below_warn_high_hys, th.ge_warn_high,
            th.below_shutdown_hys, th.ge_shutdown};
         sync2_reg <= sync1_reg;
         filt_reg <= filt_next;
         warn_high_reg <= warn_high_next;
         warn_low_reg <= warn_low_next;
      end
   end

   // Hot only once the shutdown level has held for longer than the filter.
   assign th.hot = sync2_reg[0] && (filt_reg == FILT_MAX);
   assign th.cool = sync2_reg[1];
   assign th.warn_high = warn_high_reg;
   assign th.warn_low = warn_low_reg;

   a_warn_high_set: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) sync2_reg[2] |=> warn_high_reg)
      else $error("high warning did not set");
   a_warn_low_clr: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) sync2_reg[5] && !sync2_reg[4] |=> !warn_low_reg)
      else $error("low warning did not clear");
endmodule
`default_nettype wire

//--- logic/bfs_fault_status.sv
// Notes on behaviour
// - Channel one over-temperature latches when hot beyond the filter time, and buck one is held off.
// - The channel one high thermal warning follows temperature with hysteresis and is read-only.
// - The channel one low thermal warning follows temperature with hysteresis and is read-only.
// - Channel one short on-time flag sets after more than 32 short cycles, not necessarily consecutive.
// - Buck one stays disabled while its short on-time flag is set until a read-and-clear.
// - In limp-home an auto-restart clears the channel one short on-time flag every restart period.
// - Channel two short on-time flag sets after more than 32 short cycles, not necessarily consecutive.
// - Buck two stays disabled while its short on-time flag is set until the host clears it or a limp-home auto-restart clears it.
// - Bit zero of every status word is odd parity over the word.
// - The second status register sits at address 0x06 with its documented field layout.
// - Channel one short circuit sets with its short on-time flag when average LED voltage is low.
// - A timeout guard failure outside limp-home sets its flag and enters limp-home mode.
`timescale 1ns/10ps
`default_nettype none
module bfs_fault_status
#(
   parameter int AUTORESTART_CYC = bfs_pkg::AUTORESTART_CYC
)
(
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_ch1_tj_ge_shutdown,
   input wire logic i_ch1_tj_below_shutdown_hys,
   input wire logic i_ch1_tj_ge_warn_high,
   input wire logic i_ch1_tj_below_warn_high_hys,
   input wire logic i_ch1_tj_ge_warn_low,
   input wire logic i_ch1_tj_below_warn_low_hys,
   input wire logic i_ch2_tj_ge_shutdown,
   input wire logic i_ch2_tj_below_shutdown_hys,
   input wire logic i_ch2_tj_ge_warn_high,
   input wire logic i_ch2_tj_below_warn_high_hys,
   input wire logic i_ch2_tj_ge_warn_low,
   input wire logic i_ch2_tj_below_warn_low_hys,
   input wire logic i_ch1_vled_avg_low,
   input wire logic i_dim_input_state,
   input wire logic i_ch1_cycle_done,
   input wire logic i_ch1_ontime_short,
   input wire logic i_ch2_cycle_done,
   input wire logic i_ch2_ontime_short,
   input wire logic [7:0] i_ch1_vled_adc,
   input wire logic [7:0] i_ch2_vled_adc,
   input wire logic i_ch1_long_ontime_evt,
   input wire logic i_ch2_long_ontime_evt,
   input wire logic i_dimming_clock_fault_evt,
   input wire logic i_host_supply_fault,
   input wire logic [1:0] i_wd_status,
   input wire logic i_timeout_guard_fault_evt,
   input wire logic i_battery_undervoltage,
   input wire logic i_ch1_short_offtime,
   input wire logic i_ch2_short_offtime,
   input wire logic i_ch1_long_offtime,
   input wire logic i_ch2_long_offtime,
   input wire logic i_power_not_good,
   input wire logic i_booster_feedback_fault_evt,
   input wire logic i_acc_valid,
   input wire logic [5:0] i_acc_addr,
   input wire logic i_acc_clear,
   output logic [23:0] o_acc_data,
   output logic o_acc_valid,
   output logic o_ch1_buck_en,
   output logic o_ch2_buck_en,
   output logic o_limp_home
);
   localparam logic [bfs_pkg::SHORT_CNT_W-1:0] SHORT_MAX =
      bfs_pkg::SHORT_CNT_W'(bfs_pkg::SHORT_ON_LIMIT);
   bfs_therm_if th1 ();
   bfs_therm_if th2 ();
   logic [1:0] sync1_reg, sync2_reg;
   logic [bfs_pkg::AR_CNT_W-1:0] ar_cnt_reg, ar_cnt_next;
   logic [bfs_pkg::SHORT_CNT_W-1:0] cnt1_reg, cnt1_next, cnt2_reg, cnt2_next;
   logic ch1_overtemp_latch_reg, ch1_overtemp_latch_next, ch2_overtemp_latch_reg, ch2_overtemp_latch_next;
   logic min1_reg, min1_next, min2_reg, min2_next;
   logic ch1_short_circuit_reg, ch1_short_circuit_next, sht2_reg, sht2_next;
   logic max1_reg, max1_next, max2_reg, max2_next;
   logic dclk_reg, dclk_next, wdf_reg, wdf_next, bst_reg, bst_next;
   logic limp_reg, limp_next;
   logic en1_next, en2_next;
   logic [23:0] data_next, sr1_word, sr2_word;
   logic ar_tick, clr1, clr2, ev1, ev2, set1, set2;

   assign th1.ge_shutdown = i_ch1_tj_ge_shutdown;
   assign th1.below_shutdown_hys = i_ch1_tj_below_shutdown_hys;
   assign th1.ge_warn_high = i_ch1_tj_ge_warn_high;
   assign th1.below_warn_high_hys = i_ch1_tj_below_warn_high_hys;
   assign th1.ge_warn_low = i_ch1_tj_ge_warn_low;
   assign th1.below_warn_low_hys = i_ch1_tj_below_warn_low_hys;
   assign th2.ge_shutdown = i_ch2_tj_ge_shutdown;
   assign th2.below_shutdown_hys = i_ch2_tj_below_shutdown_hys;
   assign th2.ge_warn_high = i_ch2_tj_ge_warn_high;
   assign th2.below_warn_high_hys = i_ch2_tj_below_warn_high_hys;
   assign th2.ge_warn_low = i_ch2_tj_ge_warn_low;
   assign th2.below_warn_low_hys = i_ch2_tj_below_warn_low_hys;

   bfs_therm_chan u_therm1 (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
      .th(th1.chan));
   bfs_therm_chan u_therm2 (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
      .th(th2.chan));

   always_comb
   begin
      sr1_word = bfs_pkg::SR_RESET;
      sr1_word[bfs_pkg::SR1_VLED1_HI:bfs_pkg::SR1_VLED1_LO] = i_ch1_vled_adc;
      sr1_word[bfs_pkg::SR1_VLED2_HI:bfs_pkg::SR1_VLED2_LO] = i_ch2_vled_adc;
      sr1_word[bfs_pkg::SR1_CH1_SHORT_CIRCUIT] = ch1_short_circuit_reg;
      sr1_word[bfs_pkg::SR1_SHT2] = sht2_reg;
      sr1_word[bfs_pkg::SR1_CH1_OVERTEMP_LATCH] = ch1_overtemp_latch_reg;
      sr1_word[bfs_pkg::SR1_TWH1] = th1.warn_high;
      sr1_word[bfs_pkg::SR1_TWL1] = th1.warn_low;
      sr1_word[bfs_pkg::SR1_MIN1] = min1_reg;
      sr1_word[bfs_pkg::SR1_MIN2] = min2_reg;
      sr2_word = bfs_pkg::SR_RESET;
      sr2_word[bfs_pkg::SR2_CH2_OVERTEMP_LATCH] = ch2_overtemp_latch_reg;
      sr2_word[bfs_pkg::SR2_TWH2] = th2.warn_high;
      sr2_word[bfs_pkg::SR2_TWL2] = th2.warn_low;
      sr2_word[bfs_pkg::SR2_MAX1] = max1_reg;
      sr2_word[bfs_pkg::SR2_MAX2] = max2_reg;
      sr2_word[bfs_pkg::SR2_DCLK] = dclk_reg;
      sr2_word[bfs_pkg::SR2_HSUP] = i_host_supply_fault;
      sr2_word[bfs_pkg::SR2_WDST_HI:bfs_pkg::SR2_WDST_LO] = i_wd_status;
      sr2_word[bfs_pkg::SR2_WDF] = wdf_reg;
      sr2_word[bfs_pkg::SR2_UV] = i_battery_undervoltage;
      sr2_word[bfs_pkg::SR2_TOFMIN1] = i_ch1_short_offtime;
      sr2_word[bfs_pkg::SR2_TOFMIN2] = i_ch2_short_offtime;
      sr2_word[bfs_pkg::SR2_TOFMAX1] = i_ch1_long_offtime;
      sr2_word[bfs_pkg::SR2_TOFMAX2] = i_ch2_long_offtime;
      sr2_word[bfs_pkg::SR2_NPG] = i_power_not_good;
      sr2_word[bfs_pkg::SR2_BSTFB] = bst_reg;
      sr2_word[bfs_pkg::SR2_DIN] = sync2_reg[1];
   end

   always_comb
   begin
      ar_tick = limp_reg &&
         (ar_cnt_reg == bfs_pkg::AR_CNT_W'(AUTORESTART_CYC - 1));
      ar_cnt_next = (!limp_reg || ar_tick) ? '0 : ar_cnt_reg + 1'b1;
      clr1 = i_acc_valid && i_acc_clear && (i_acc_addr == bfs_pkg::SR1_ADDR);
      clr2 = i_acc_valid && i_acc_clear && (i_acc_addr == bfs_pkg::SR2_ADDR);
      ev1 = i_ch1_cycle_done && i_ch1_ontime_short && !min1_reg;
      ev2 = i_ch2_cycle_done && i_ch2_ontime_short && !min2_reg;
      set1 = ev1 && (cnt1_reg == SHORT_MAX);
      set2 = ev2 && (cnt2_reg == SHORT_MAX);
      // A set arriving with a clear wins, so no event is lost.
      min1_next = set1 || (min1_reg && !(clr1 || ar_tick));
      min2_next = set2 || (min2_reg && !(clr1 || ar_tick));
      cnt1_next = cnt1_reg;
      if (min1_reg && !min1_next)
      begin
         cnt1_next = '0;
      end
      else if (ev1 && cnt1_reg != SHORT_MAX)
      begin
         cnt1_next = cnt1_reg + 1'b1;
      end
      cnt2_next = cnt2_reg;
      if (min2_reg && !min2_next)
      begin
         cnt2_next = '0;
      end
      else if (ev2 && cnt2_reg != SHORT_MAX)
      begin
         cnt2_next = cnt2_reg + 1'b1;
      end
      ch1_short_circuit_next = (set1 && sync2_reg[0]) ||
         (ch1_short_circuit_reg && !(clr1 || ar_tick));
      sht2_next = sht2_reg && !clr1;
      ch1_overtemp_latch_next = th1.hot ||
         (ch1_overtemp_latch_reg && !((clr1 && th1.cool) || ar_tick));
      ch2_overtemp_latch_next = th2.hot || (ch2_overtemp_latch_reg && !((clr2 && th2.cool) || ar_tick));
      max1_next = i_ch1_long_ontime_evt || (max1_reg && !(clr2 || ar_tick));
      max2_next = i_ch2_long_ontime_evt || (max2_reg && !clr2);
      dclk_next = i_dimming_clock_fault_evt || (dclk_reg && !clr2);
      bst_next = i_booster_feedback_fault_evt || (bst_reg && !clr2);
      wdf_next = (i_timeout_guard_fault_evt && !limp_reg) ||
         (wdf_reg && !clr2);
      limp_next = wdf_next || i_host_supply_fault;
      en1_next = !(ch1_overtemp_latch_next || min1_next || ch1_short_circuit_next);
      en2_next = !(ch2_overtemp_latch_next || min2_next || sht2_next);
      data_next = o_acc_data;
      if (i_acc_valid)
      begin
         data_next = bfs_pkg::SR_RESET;
         if (i_acc_addr == bfs_pkg::SR1_ADDR)
         begin
            data_next = sr1_word;
         end
         else if (i_acc_addr == bfs_pkg::SR2_ADDR)
         begin
            data_next = sr2_word;
         end
         data_next[bfs_pkg::PAR_BIT] = ~^data_next[23:1];
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         ar_cnt_reg <= '0;
         cnt1_reg <= '0;
         cnt2_reg <= '0;
         {ch1_overtemp_latch_reg, ch2_overtemp_latch_reg, min1_reg, min2_reg} <= '0;
         {ch1_short_circuit_reg, sht2_reg, max1_reg, max2_reg} <= '0;
         {dclk_reg, wdf_reg, bst_reg, limp_reg} <= '0;
         o_acc_data <= bfs_pkg::SR_RESET;
         o_acc_valid <= 1'b0;
         o_ch1_buck_en <= 1'b0;
         o_ch2_buck_en <= 1'b0;
         o_limp_home <= 1'b0;
      end
      else
      begin
         sync1_reg <= {i_dim_input_state, i_ch1_vled_avg_low};
         sync2_reg <= sync1_reg;
         ar_cnt_reg <= ar_cnt_next;
         cnt1_reg <= cnt1_next;
         cnt2_reg <= cnt2_next;
         {ch1_overtemp_latch_reg, ch2_overtemp_latch_reg, min1_reg, min2_reg} <=
            {ch1_overtemp_latch_next, ch2_overtemp_latch_next, min1_next, min2_next};
         {ch1_short_circuit_reg, sht2_reg, max1_reg, max2_reg} <=
            {ch1_short_circuit_next, sht2_next, max1_next, max2_next};
         {dclk_reg, wdf_reg, bst_reg, limp_reg} <=
            {dclk_next, wdf_next, bst_next, limp_next};
         o_acc_data <= data_next;
         o_acc_valid <= i_acc_valid;
         o_ch1_buck_en <= en1_next;
         o_ch2_buck_en <= en2_next;
         o_limp_home <= limp_next;
      end
   end

   a_ch1_overtemp_latch_latch: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) th1.hot |=> ch1_overtemp_latch_reg && !o_ch1_buck_en)
      else $error("overtemp did not latch");
   a_ch1_overtemp_latch_hot_hold: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) ch1_overtemp_latch_reg && clr1 && !th1.cool && !limp_reg
      |=> ch1_overtemp_latch_reg) else $error("overtemp cleared while hot");
   a_min1_set: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) ev1 && cnt1_reg == SHORT_MAX |=> min1_reg)
      else $error("short on-time one missed");
   a_buck1_hold: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) min1_reg && !clr1 && !ar_tick
      |=> min1_reg && !o_ch1_buck_en) else $error("buck one not held");
   a_min1_restart: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) ar_tick && min1_reg |=> !min1_reg)
      else $error("auto restart failed");
   a_min2_set: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) ev2 && cnt2_reg == SHORT_MAX
      |=> min2_reg && !o_ch2_buck_en) else $error("short on-time two missed");
   a_buck2_hold: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) min2_reg && !clr1 && !ar_tick
      |=> !o_ch2_buck_en) else $error("buck two not held");
   a_odd_parity: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) o_acc_valid |-> ^o_acc_data)
      else $error("status parity not odd");
   a_sr2_layout: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) i_acc_valid && i_acc_addr == bfs_pkg::SR2_ADDR
      |=> o_acc_data[bfs_pkg::SR2_CH2_OVERTEMP_LATCH] == $past(ch2_overtemp_latch_reg)
      && o_acc_data[bfs_pkg::SR2_WDF] == $past(wdf_reg))
      else $error("second register word wrong");
   a_ch1_short_circuit_set: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) set1 && sync2_reg[0] |=> ch1_short_circuit_reg && min1_reg)
      else $error("short circuit missed");
   a_guard_limp: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) i_timeout_guard_fault_evt && !limp_reg
      |=> wdf_reg && o_limp_home) else $error("limp home not entered");
   a_cnt_restart: assert property (@(posedge i_clk_sys)
      disable iff (i_sys_rst) $fell(min1_reg) |-> cnt1_reg == '0)
      else $error("counter not restarted");
endmodule
`default_nettype wire

//--- testbench/bfs_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module bfs_host_model
(
   input wire logic i_clk_sys,
   input wire logic i_acc_valid,
   input wire logic [23:0] i_acc_data,
   output logic [7:0] o_par_err
);
   logic [7:0] errs = 8'h00;
   assign o_par_err = errs;
   // Every returned word must carry an odd count of ones.
   always @(posedge i_clk_sys)
   begin
      if (i_acc_valid === 1'b1 && (^i_acc_data) !== 1'b1)
      begin
         errs <= errs + 8'h01;
      end
   end
endmodule
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic i_clk_sys, i_sys_rst, i_ch1_tj_ge_shutdown;
   logic i_ch1_tj_below_shutdown_hys, i_ch1_tj_ge_warn_high;
   logic i_ch1_tj_below_warn_high_hys, i_ch1_tj_ge_warn_low;
   logic i_ch1_tj_below_warn_low_hys, i_ch2_tj_ge_shutdown;
   logic i_ch2_tj_below_shutdown_hys, i_ch2_tj_ge_warn_high;
   logic i_ch2_tj_below_warn_high_hys, i_ch2_tj_ge_warn_low;
   logic i_ch2_tj_below_warn_low_hys, i_ch1_vled_avg_low;
   logic i_dim_input_state, i_ch1_cycle_done, i_ch1_ontime_short;
   logic i_ch2_cycle_done, i_ch2_ontime_short;
   logic [7:0] i_ch1_vled_adc, i_ch2_vled_adc;
   logic i_ch1_long_ontime_evt, i_ch2_long_ontime_evt;
   logic i_dimming_clock_fault_evt, i_host_supply_fault;
   logic [1:0] i_wd_status;
   logic i_timeout_guard_fault_evt, i_battery_undervoltage;
   logic i_ch1_short_offtime, i_ch2_short_offtime, i_ch1_long_offtime;
   logic i_ch2_long_offtime, i_power_not_good;
   logic i_booster_feedback_fault_evt, i_acc_valid, i_acc_clear;
   logic [5:0] i_acc_addr;
   logic [23:0] o_acc_data, d, w;
   logic o_acc_valid, o_ch1_buck_en, o_ch2_buck_en, o_limp_home;
   logic [7:0] par_err;
   int err_count = 0;
   int checked = 0;
   localparam logic [15:0] ADC = 16'h5A3C;

   bfs_fault_status #(.AUTORESTART_CYC(50)) u_bfs_fault_status
   (
      .i_clk_sys, .i_sys_rst, .i_ch1_tj_ge_shutdown,
      .i_ch1_tj_below_shutdown_hys, .i_ch1_tj_ge_warn_high,
      .i_ch1_tj_below_warn_high_hys, .i_ch1_tj_ge_warn_low,
      .i_ch1_tj_below_warn_low_hys, .i_ch2_tj_ge_shutdown,
      .i_ch2_tj_below_shutdown_hys, .i_ch2_tj_ge_warn_high,
      .i_ch2_tj_below_warn_high_hys, .i_ch2_tj_ge_warn_low,
      .i_ch2_tj_below_warn_low_hys, .i_ch1_vled_avg_low,
      .i_dim_input_state, .i_ch1_cycle_done, .i_ch1_ontime_short,
      .i_ch2_cycle_done, .i_ch2_ontime_short, .i_ch1_vled_adc,
      .i_ch2_vled_adc, .i_ch1_long_ontime_evt, .i_ch2_long_ontime_evt,
      .i_dimming_clock_fault_evt, .i_host_supply_fault, .i_wd_status,
      .i_timeout_guard_fault_evt, .i_battery_undervoltage,
      .i_ch1_short_offtime, .i_ch2_short_offtime, .i_ch1_long_offtime,
      .i_ch2_long_offtime, .i_power_not_good,
      .i_booster_feedback_fault_evt, .i_acc_valid, .i_acc_addr,
      .i_acc_clear, .o_acc_data, .o_acc_valid, .o_ch1_buck_en,
      .o_ch2_buck_en, .o_limp_home
   );

   bfs_host_model u_bfs_host_model
   (
      .i_clk_sys(i_clk_sys),
      .i_acc_valid(o_acc_valid),
      .i_acc_data(o_acc_data),
      .o_par_err(par_err)
   );

   initial
   begin
      i_clk_sys = 1'b0;
      forever #12.5 i_clk_sys = ~i_clk_sys;
   end

   function automatic logic [23:0] par(input logic [23:0] v);
      return {v[23:1], ~^v[23:1]};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask

   task automatic chk(input string n, input logic [23:0] e,
                      input logic [23:0] s);
      checked++;
      if (s !== e)
      begin
         err_count++;
         $display("MISMATCH %s expected=%h seen=%h", n, e, s);
      end
   endtask

   // One register access; the answer is taken one edge after the request.
   task automatic acc(input logic [5:0] a, input logic c);
      @(posedge i_clk_sys);
      i_acc_valid <= 1'b1;
      i_acc_addr <= a;
      i_acc_clear <= c;
      @(posedge i_clk_sys);
      i_acc_valid <= 1'b0;
      i_acc_clear <= 1'b0;
      #1;
      chk("acc_valid", 24'h00_0001, {23'h00_0000, o_acc_valid});
      d = o_acc_data;
   endtask

   task automatic ev(input int ch, input logic s);
      @(posedge i_clk_sys);
      i_ch1_cycle_done <= (ch == 1);
      i_ch2_cycle_done <= (ch == 2);
      i_ch1_ontime_short <= s;
      i_ch2_ontime_short <= s;
      @(posedge i_clk_sys);
      i_ch1_cycle_done <= 1'b0;
      i_ch2_cycle_done <= 1'b0;
   endtask

   // Short cycles separated by normal ones, so none are consecutive.
   task automatic shorts(input int ch, input int n);
      repeat (n)
      begin
         ev(ch, 1'b1);
         ev(ch, 1'b0);
      end
   endtask

   task automatic print_verdict();
      chk("parity_errors", 24'h00_0000, {16'h0000, par_err});
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge i_clk_sys);
      err_count++;
      print_verdict();
   end

   initial
   begin
      {i_ch1_tj_ge_shutdown, i_ch1_tj_ge_warn_high, i_ch1_tj_ge_warn_low} = '0;
      {i_ch2_tj_ge_shutdown, i_ch2_tj_ge_warn_high, i_ch2_tj_ge_warn_low} = '0;
      {i_ch1_tj_below_shutdown_hys, i_ch1_tj_below_warn_high_hys} = 2'b11;
      {i_ch2_tj_below_shutdown_hys, i_ch2_tj_below_warn_high_hys} = 2'b11;
      {i_ch1_tj_below_warn_low_hys, i_ch2_tj_below_warn_low_hys} = 2'b11;
      {i_ch1_cycle_done, i_ch1_ontime_short} = 2'b00;
      {i_ch2_cycle_done, i_ch2_ontime_short} = 2'b00;
      {i_ch1_vled_adc, i_ch2_vled_adc} = ADC;
      {i_ch1_long_ontime_evt, i_ch2_long_ontime_evt} = 2'b00;
      {i_dimming_clock_fault_evt, i_host_supply_fault} = 2'b00;
      {i_timeout_guard_fault_evt, i_battery_undervoltage} = 2'b00;
      {i_ch1_short_offtime, i_ch2_short_offtime} = 2'b00;
      {i_ch1_long_offtime, i_ch2_long_offtime, i_power_not_good} = '0;
      {i_booster_feedback_fault_evt, i_acc_valid, i_acc_clear} = '0;
      {i_dim_input_state, i_wd_status, i_acc_addr} = '0;
      i_ch1_vled_avg_low = 1'b1;
      i_sys_rst = 1'b1;
      repeat (16) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      tick(4);
      acc(bfs_pkg::SR1_ADDR, 1'b0);
      chk("sr1_idle", par({ADC, 8'h00}), d);
      acc(bfs_pkg::SR2_ADDR, 1'b0);
      chk("sr2_idle", 24'h00_0001, d);
      acc(6'h07, 1'b0);
      chk("unmapped", 24'h00_0001, d);
      shorts(1, 32);
      tick(2);
      chk("buck1_32", 24'h00_0001, {23'h0, o_ch1_buck_en});
      shorts(1, 1);
      tick(20);
      chk("buck1_33", 24'h00_0000, {23'h0, o_ch1_buck_en});
      acc(bfs_pkg::SR1_ADDR, 1'b0);
      chk("sr1_min1", par({ADC, 8'h84}), d);
      acc(bfs_pkg::SR1_ADDR, 1'b1);
      chk("sr1_rc", par({ADC, 8'h84}), d);
      chk("buck1_rc", 24'h00_0001, {23'h0, o_ch1_buck_en});
      acc(bfs_pkg::SR1_ADDR, 1'b0);
      chk("sr1_clr", par({ADC, 8'h00}), d);
      shorts(1, 32);
      tick(2);
      chk("buck1_recount", 24'h00_0001, {23'h0, o_ch1_buck_en});
      shorts(2, 33);
      tick(20);
      chk("buck2_33", 24'h00_0000, {23'h0, o_ch2_buck_en});
      acc(bfs_pkg::SR1_ADDR, 1'b1);
      chk("sr1_min2", 24'h00_0001, {23'h0, d[bfs_pkg::SR1_MIN2]});
      chk("buck2_rc", 24'h00_0001, {23'h0, o_ch2_buck_en});
      i_ch1_tj_ge_warn_high <= 1'b1;
      i_ch1_tj_ge_warn_low <= 1'b1;
      i_ch1_tj_below_warn_high_hys <= 1'b0;
      i_ch1_tj_below_warn_low_hys <= 1'b0;
      tick(5);
      acc(bfs_pkg::SR1_ADDR, 1'b1);
      chk("warn_set", 24'h00_0003, {22'h0, d[4:3]});
      i_ch1_tj_ge_warn_high <= 1'b0;
      i_ch1_tj_ge_warn_low <= 1'b0;
      tick(5);
      acc(bfs_pkg::SR1_ADDR, 1'b0);
      chk("warn_hys", 24'h00_0003, {22'h0, d[4:3]});
      i_ch1_tj_below_warn_high_hys <= 1'b1;
      tick(5);
      acc(bfs_pkg::SR1_ADDR, 1'b0);
      chk("warn_high_off", 24'h00_0001, {22'h0, d[4:3]});
      i_ch1_tj_below_warn_low_hys <= 1'b1;
      tick(5);
      acc(bfs_pkg::SR1_ADDR, 1'b0);
      chk("warn_low_off", 24'h00_0000, {22'h0, d[4:3]});
      i_ch1_tj_ge_shutdown <= 1'b1;
      i_ch1_tj_below_shutdown_hys <= 1'b0;
      tick(780);
      chk("ovt_filter", 24'h00_0001, {23'h0, o_ch1_buck_en});
      tick(40);
      chk("ovt_off", 24'h00_0000, {23'h0, o_ch1_buck_en});
      acc(bfs_pkg::SR1_ADDR, 1'b1);
      acc(bfs_pkg::SR1_ADDR, 1'b0);
      chk("ovt_hot_rc", par({ADC, 8'h20}), d);
      chk("ovt_hot_buck", 24'h00_0000, {23'h0, o_ch1_buck_en});
      i_ch1_tj_ge_shutdown <= 1'b0;
      i_ch1_tj_below_shutdown_hys <= 1'b1;
      tick(5);
      acc(bfs_pkg::SR1_ADDR, 1'b1);
      chk("ovt_cool_buck", 24'h00_0001, {23'h0, o_ch1_buck_en});
      acc(bfs_pkg::SR1_ADDR, 1'b0);
      chk("ovt_cleared", par({ADC, 8'h00}), d);
      i_wd_status <= 2'b10;
      i_battery_undervoltage <= 1'b1;
      i_ch1_short_offtime <= 1'b1;
      i_ch2_long_offtime <= 1'b1;
      i_power_not_good <= 1'b1;
      i_dim_input_state <= 1'b1;
      i_ch2_tj_ge_warn_low <= 1'b1;
      i_ch2_tj_below_warn_low_hys <= 1'b0;
      i_ch1_long_ontime_evt <= 1'b1;
      i_dimming_clock_fault_evt <= 1'b1;
      i_booster_feedback_fault_evt <= 1'b1;
      tick(1);
      i_ch1_long_ontime_evt <= 1'b0;
      i_dimming_clock_fault_evt <= 1'b0;
      i_booster_feedback_fault_evt <= 1'b0;
      tick(5);
      w = 24'h00_0000;
      w[bfs_pkg::SR2_WDST_HI] = 1'b1;
      w[bfs_pkg::SR2_UV] = 1'b1;
      w[bfs_pkg::SR2_TOFMIN1] = 1'b1;
      w[bfs_pkg::SR2_TOFMAX2] = 1'b1;
      w[bfs_pkg::SR2_NPG] = 1'b1;
      w[bfs_pkg::SR2_DIN] = 1'b1;
      w[bfs_pkg::SR2_TWL2] = 1'b1;
      acc(bfs_pkg::SR2_ADDR, 1'b1);
      chk("sr2_latched", par(w | 24'h14_0040), d);
      acc(bfs_pkg::SR2_ADDR, 1'b0);
      chk("sr2_live", par(w), d);
      ev(1, 1'b1);
      tick(3);
      chk("buck1_again", 24'h00_0000, {23'h0, o_ch1_buck_en});
      i_timeout_guard_fault_evt <= 1'b1;
      tick(1);
      i_timeout_guard_fault_evt <= 1'b0;
      tick(3);
      chk("limp_on", 24'h00_0001, {23'h0, o_limp_home});
      for (int i = 0; i < 60 && o_ch1_buck_en !== 1'b1; i++)
         tick(1);
      chk("limp_restart", 24'h00_0001, {23'h0, o_ch1_buck_en});
      acc(bfs_pkg::SR2_ADDR, 1'b1);
      chk("wd_flag", 24'h00_0001, {23'h0, d[bfs_pkg::SR2_WDF]});
      tick(3);
      chk("limp_off", 24'h00_0000, {23'h0, o_limp_home});
      print_verdict();
   end
endmodule
`default_nettype wire
